// >>> hdl/ptc_timer.sv
// Periodic timer unit: 10-bit counter, capture input mode, single pulse trigger.
// Assumes one 50 MHz clock, an AXI4-Lite master, and async capture and clock pins.
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Mode bits 01 select capture mode.
// R2 - Source bit picks capture pin or clock pin.
// R3 - Instance 0 field routes pin or comparator.
// R4 - Edge select; both bits high: no capture.
// R5 - Run rising starts counter; runs until falling.
// R6 - Capture copies count into A or B, interrupts.
// R7 - Destination depends on edge and clear settings.
// R8 - Edge and clear settings act independently.
// R9 - Period match resets counter to zero.
// R10 - Period match in capture mode interrupts.
// R11 - Period zero runs to full count.
// R12 - Clear field 00: period match only.
// R13 - Clear field 01: rising edge also clears.
// R14 - Clear field 10: falling edge also clears.
// R15 - Clear field 11: either edge also clears.
// R16 - Source holds capture pulses two clocks minimum.
// R17 - Timer clock must not exceed 50 MHz.
// R18 - Capture mode drives no output; bits ignored.
// R19 - Instances 1, 2: pin only, always A.
// R20 - Single pulse: clock pin edge sets run.
// R21 - Software keeps edge bits 11 in single pulse.
// R22 - Pulse starts by pin or software; no period.
// R23 - Single pulse: compare A match clears run.
// R24 - Counter and period are ten bits.
// R25 - Edges found by comparing sampled levels.
module ptc_timer
  import ptc_pkg::*;
#(
  parameter int INST = 0                     // Timer instance number, 0 to 2.
)(
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              capPin,
  input  wire logic              tckPin,
  input  wire logic              internalCap,
  output logic                   timerOut,
  output logic                   timerIrq,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [1:0]        rstSync_ff;             // Reset release synchroniser.
  logic              rstnSys;                // Synchronised reset.
  logic [1:0]        capSync_ff;             // Capture pin synchroniser.
  logic [1:0]        tckSync_ff;             // Clock pin synchroniser.
  logic              capPrev_ff;             // Previous capture level.
  logic              tckPrev_ff;             // Previous clock pin level.
  logic [CTRL_W-1:1] ctrl_ff;                // Control fields above run.
  logic              run_ff;                 // counter_run_bit.
  logic              runPrev_ff;             // Run bit one cycle ago.
  logic [1:0]        inSrc_ff;               // Input source field.
  logic [CNT_W-1:0]  period_ff;              // period_compare_value.
  logic [CNT_W-1:0]  compare_capture_a_ff;                // compare_capture_a.
  logic [CNT_W-1:0]  capture_reg_b_ff;                // capture_reg_b.
  logic [CNT_W-1:0]  count_ff;               // Counter.
  logic [2:0]        flags_ff;               // Sticky event flags.
  logic [ADDR_W-1:0] awAddr_ff;              // Held write address.
  logic [31:0]       wData_ff;               // Held write data.
  logic [3:0]        wStrb_ff;               // Held write strobes.
  logic              doWrite;                // Register write this cycle.
  logic [31:0]       wMask;                  // Byte strobes spread to bits.
  logic [31:0]       wVal;                   // Masked write data.
  logic [31:0]       nxt_rdata;              // Read multiplexer.
  logic              nxt_rerr;               // Unmapped read.
  logic [1:0]        mode;                   // Mode select field.
  logic [1:0]        edgeSel;                // Edge select field.
  logic [1:0]        clrSel;                 // Clear condition field.
  logic              capMode;                // Capture input mode.
  logic              spMode;                 // Single pulse mode.
  logic              capSig;                 // Selected capture signal.
  logic              capRise;                // Rising capture edge.
  logic              capFall;                // Falling capture edge.
  logic              tckRise;                // Clock pin active edge.
  logic              capTrig;                // Qualifying capture edge.
  logic              capToB;                 // Capture lands in B.
  logic              edgeClr;                // Capture edge clears counter.
  logic              perHit;                 // Period compare match.
  logic              cmpAHit;                // Compare A match, single pulse.
  logic              runRise;                // Run bit went high.
  logic              swRunSet;               // Software writes run high.
  logic              swRunClr;               // Software writes run low.
  logic [CNT_W-1:0]  nxt_count;              // Next counter value.
  logic [2:0]        events;                 // Flag set terms.

  // ****************************************************************
  // Reset and pin synchronisers
  // ****************************************************************
  // Reset is released through two flip-flops.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn) rstSync_ff <= 2'h0;
    else       rstSync_ff <= {rstSync_ff[0], 1'b1};
  end
  assign rstnSys = rstSync_ff[1];

  // Pins are sampled twice; only the second stage feeds any logic.
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
    begin
      capSync_ff <= 2'h0;
      tckSync_ff <= 2'h0;
    end
    else if (ce)
    begin
      capSync_ff <= {capSync_ff[0], capPin};
      tckSync_ff <= {tckSync_ff[0], tckPin};
    end
  end

  // ****************************************************************
  // Capture source selection and edge detection
  // ****************************************************************
  assign mode    = ctrl_ff[B_MODE+1:B_MODE];
  assign edgeSel = ctrl_ff[B_EDGE+1:B_EDGE];
  assign clrSel  = ctrl_ff[B_CLR+1:B_CLR];
  assign capMode = (mode == MODE_CAP); // R1
  assign spMode  = (mode == MODE_PWM) && (edgeSel == EDGE_NONE);

  // The comparator signal is on this clock and needs no synchroniser.
  always_comb
  begin
    if (ctrl_ff[B_CAPSRC])
      capSig = tckSync_ff[1]; // R2
    else if ((INST == 0) && (inSrc_ff != SRC_PIN))
      capSig = internalCap; // R3
    else
      capSig = capSync_ff[1]; // R19
  end

  // Previous levels for edge detection.
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
    begin
      capPrev_ff <= 1'b0;
      tckPrev_ff <= 1'b0;
    end
    else if (ce)
    begin
      capPrev_ff <= capSig;
      tckPrev_ff <= tckSync_ff[1];
    end
  end
  assign capRise = capSig && !capPrev_ff; // R25
  assign capFall = !capSig && capPrev_ff; // R25
  assign tckRise = tckSync_ff[1] && !tckPrev_ff;

  // Edge select gates capture and single pulse; clear field gates clearing and picks register B.
  always_comb
  begin
    case (edgeSel) // R4 R8
      EDGE_RISE: capTrig = capMode && capRise;
      EDGE_FALL: capTrig = capMode && capFall;
      EDGE_BOTH: capTrig = capMode && (capRise || capFall);
      default:   capTrig = 1'b0;
    endcase
  end

  always_comb
  begin
    edgeClr = 1'b0;
    capToB  = 1'b0;
    if (INST == 0)
    begin
      case (clrSel) // R8
        CLR_RISE:
        begin
          edgeClr = capRise; // R13
          capToB  = capFall; // R7
        end
        CLR_FALL:
        begin
          edgeClr = capFall; // R14
          capToB  = capRise; // R7
        end
        CLR_ANY:
        begin
          edgeClr = capRise || capFall; // R15
          capToB  = capFall; // R7
        end
        default:
        begin
          edgeClr = 1'b0; // R12
          capToB  = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Period zero means wrap at the full count.
  // The first cycle of a run still holds a stale count, so no match may fire then.
  assign perHit  = run_ff && !runRise && !spMode &&
                   ((period_ff == '0) ? (count_ff == CNT_MAX) : (count_ff == period_ff)); // R11
  assign cmpAHit = run_ff && !runRise && spMode && (count_ff == compare_capture_a_ff);
  assign runRise = run_ff && !runPrev_ff;

  always_comb
  begin
    if (runRise)
      nxt_count = '0; // R5
    else if (!run_ff)
      nxt_count = count_ff;
    else if (perHit || (capMode && edgeClr))
      nxt_count = '0; // R9
    else
      nxt_count = count_ff + 1'b1; // R24
  end

  // Counter and run history.
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
    begin
      count_ff   <= '0;
      runPrev_ff <= 1'b0;
    end
    else if (ce)
    begin
      count_ff   <= nxt_count;
      runPrev_ff <= run_ff;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wMask   = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
  assign wVal    = wData_ff & wMask;
  assign swRunSet = doWrite && (awAddr_ff == OFF_CTRL) && wStrb_ff[0] && wData_ff[B_RUN];
  assign swRunClr = doWrite && (awAddr_ff == OFF_CTRL) && wStrb_ff[0] && !wData_ff[B_RUN];

  // Control, source and period registers.
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
    begin
      ctrl_ff   <= '0;
      inSrc_ff  <= 2'h0;
      period_ff <= '0;
    end
    else if (ce && doWrite)
    begin
      case (awAddr_ff)
        OFF_CTRL:   ctrl_ff   <= (ctrl_ff & ~wMask[CTRL_W-1:1]) | wVal[CTRL_W-1:1];
        OFF_INSRC:  inSrc_ff  <= wStrb_ff[0] ? wData_ff[B_INSRC+1:B_INSRC] : inSrc_ff;
        OFF_PERIOD: period_ff <= (period_ff & ~wMask[CNT_W-1:0]) | wVal[CNT_W-1:0];
        default:    ;
      endcase
    end
  end

  // Run bit: hardware pulse end wins, then pin start, then software.
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys) run_ff <= 1'b0;
    else if (ce)
    begin
      if (cmpAHit) run_ff <= 1'b0; // R23
      else if (spMode && tckRise) run_ff <= 1'b1; // R20 R22
      else if (swRunSet) run_ff <= 1'b1; // R22
      else if (swRunClr) run_ff <= 1'b0;
    end
  end

  // Capture registers: a capture beats a software write to A.
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
    begin
      compare_capture_a_ff <= '0;
      capture_reg_b_ff <= '0;
    end
    else if (ce)
    begin
      if (capTrig && capToB) capture_reg_b_ff <= count_ff; // R6 R7
      else if (capTrig) compare_capture_a_ff <= count_ff; // R6 R19
      else if (doWrite && (awAddr_ff == OFF_COMPARE_CAPTURE_A))
        compare_capture_a_ff <= (compare_capture_a_ff & ~wMask[CNT_W-1:0]) | wVal[CNT_W-1:0];
    end
  end

  // Sticky flags: a new event wins over a write-one clear.
  assign events = {cmpAHit, perHit, capTrig};
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys) flags_ff <= 3'h0;
    else if (ce)
    begin
      if (doWrite && (awAddr_ff == OFF_STAT))
        flags_ff <= (flags_ff & ~wVal[2:0]) | events;
      else
        flags_ff <= flags_ff | events;
    end
  end

  // ****************************************************************
  // Timer outputs
  // ****************************************************************
  // Interrupt is high the cycle after each cycle with any event; output is quiet outside single pulse.
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
    begin
      timerIrq <= 1'b0;
      timerOut <= 1'b0;
    end
    else if (ce)
    begin
      timerIrq <= |events; // R6 R10
      timerOut <= spMode && run_ff && !cmpAHit; // R18
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data are taken in either order; the write follows both.
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awAddr_ff     <= '0;
      wData_ff      <= '0;
      wStrb_ff      <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_ff     <= s_axi_wdata;
        wStrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_ff <= OFF_COUNT && awAddr_ff[1:0] == 2'h0 &&
                         awAddr_ff != OFF_CAPTURE_REG_B && awAddr_ff != OFF_COUNT) ?
                        RESP_OKAY : RESP_SLV;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  // Read multiplexer; unused bits read zero, unmapped gives SLVERR.
  always_comb
  begin
    nxt_rdata = 32'h0;
    nxt_rerr  = 1'b0;
    case (s_axi_araddr)
      OFF_CTRL:   nxt_rdata[CTRL_W-1:0] = {ctrl_ff, run_ff};
      OFF_INSRC:  nxt_rdata[B_INSRC+1:B_INSRC] = inSrc_ff;
      OFF_PERIOD: nxt_rdata[CNT_W-1:0] = period_ff;
      OFF_COMPARE_CAPTURE_A:   nxt_rdata[CNT_W-1:0] = compare_capture_a_ff;
      OFF_CAPTURE_REG_B:   nxt_rdata[CNT_W-1:0] = capture_reg_b_ff;
      OFF_STAT:   nxt_rdata[2:0] = flags_ff;
      OFF_COUNT:  nxt_rdata[CNT_W-1:0] = count_ff;
      default:    nxt_rerr = 1'b1;
    endcase
  end

  // One read at a time; data answers one cycle after the address.
  always_ff @(posedge clk_sys or negedge rstnSys)
  begin
    if (!rstnSys)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= nxt_rdata;
        s_axi_rresp   <= nxt_rerr ? RESP_SLV : RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // A capture may only happen under the raw capture mode encoding.
  mode_decode_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R1
    capTrig |-> (mode == 2'h1)) else $error("capture outside capture mode");
  no_capture_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R4
    (edgeSel == EDGE_NONE) |-> !capTrig) else $error("capture with edges off");
  run_start_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R5
    (ce && runRise) |=> (count_ff == '0)) else $error("counter not zero at start");
  capture_a_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R6
    (ce && capTrig && !capToB) |=> (compare_capture_a_ff == $past(count_ff)))
    else $error("capture A missed");
  capture_b_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R7
    (ce && capTrig && capToB) |=> (capture_reg_b_ff == $past(count_ff)))
    else $error("capture B missed");
  period_clear_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R9
    (ce && perHit && !runRise) |=> (count_ff == '0) && timerIrq)
    else $error("period match not handled");
  full_wrap_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R11
    (ce && run_ff && !spMode && period_ff == '0 && count_ff == 10'h3fe && !runRise &&
     !(capMode && edgeClr)) |=> (count_ff == 10'h3ff))
    else $error("zero period stopped early");
  rise_clear_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R13
    (ce && run_ff && capMode && clrSel == CLR_RISE && capRise && INST == 0)
    |=> (count_ff == '0)) else $error("rising edge did not clear");
  quiet_out_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R18
    capMode [*2] |-> !timerOut) else $error("output driven in capture mode");
  pulse_end_a: assert property (@(posedge clk_sys) disable iff (!rstnSys) // R23
    (ce && cmpAHit) |=> !run_ff ##1 !timerOut) else $error("pulse did not end");
  cap_irq_c: cover property (@(posedge clk_sys) disable iff (!rstnSys)
    capTrig ##1 timerIrq);
  cap_b_c: cover property (@(posedge clk_sys) disable iff (!rstnSys)
    capTrig && capToB);
  pulse_c: cover property (@(posedge clk_sys) disable iff (!rstnSys)
    spMode && tckRise ##[1:100] cmpAHit);
endmodule

// >>> include/ptc_pkg.sv
// Constants for the periodic timer with capture input and single pulse trigger.
// Assumes an AXI4-Lite register bus with 32-bit data and byte addresses.
package ptc_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CNT_W  = 10;                  // Counter and compare width.
  localparam int ADDR_W = 8;                   // Register byte address width.
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00;   // timer_control_reg_one.
  localparam logic [7:0] OFF_INSRC  = 8'h04;   // input_source_select_reg.
  localparam logic [7:0] OFF_PERIOD = 8'h08;   // period_compare_value.
  localparam logic [7:0] OFF_COMPARE_CAPTURE_A   = 8'h0c;   // compare_capture_a.
  localparam logic [7:0] OFF_CAPTURE_REG_B   = 8'h10;   // capture_reg_b, read only.
  localparam logic [7:0] OFF_STAT   = 8'h14;   // Event flags, write one to clear.
  localparam logic [7:0] OFF_COUNT  = 8'h18;   // Live counter, read only.
  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int B_RUN    = 0;                 // counter_run_bit.
  localparam int B_MODE   = 1;                 // mode_select_lo, hi at +1.
  localparam int B_CAPSRC = 3;                 // capture_source_select.
  localparam int B_EDGE   = 4;                 // edge_select_lo, hi at +1.
  localparam int B_CLR    = 6;                 // clear_condition_lo, hi at +1.
  localparam int B_CCLR   = 8;                 // clear_on_a_select.
  localparam int B_OC     = 9;                 // output_initial_level.
  localparam int B_POL    = 10;                // output_polarity.
  localparam int CTRL_W   = 11;                // Stored control width.
  localparam int B_INSRC  = 6;                 // Input source field, two bits.
  localparam int B_F_CAP  = 0;                 // Capture event flag.
  localparam int B_F_PER  = 1;                 // Period match flag.
  localparam int B_F_CMPA = 2;                 // Compare A match flag.
  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0] MODE_CMP  = 2'h0;     // Compare match output.
  localparam logic [1:0] MODE_CAP  = 2'h1;     // Capture input.
  localparam logic [1:0] MODE_PWM  = 2'h2;     // PWM or single pulse.
  localparam logic [1:0] EDGE_RISE = 2'h0;     // Capture on rising edge.
  localparam logic [1:0] EDGE_FALL = 2'h1;     // Capture on falling edge.
  localparam logic [1:0] EDGE_BOTH = 2'h2;     // Capture on both edges.
  localparam logic [1:0] EDGE_NONE = 2'h3;     // No capture; single pulse code.
  localparam logic [1:0] CLR_PER   = 2'h0;     // Period match only.
  localparam logic [1:0] CLR_RISE  = 2'h1;     // Also rising capture edge.
  localparam logic [1:0] CLR_FALL  = 2'h2;     // Also falling capture edge.
  localparam logic [1:0] CLR_ANY   = 2'h3;     // Also either capture edge.
  localparam logic [1:0] SRC_PIN   = 2'h0;     // External capture pin.
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff; // Full count.
  localparam logic [1:0] RESP_OKAY = 2'h0;     // AXI OKAY.
  localparam logic [1:0] RESP_SLV  = 2'h2;     // AXI SLVERR.
endpackage

// >>> sim/ptc_cap_src.sv
// Model of the pulse source on the far side of the capture pin.
// Assumes the bench clock; pulses are counted in its cycles.
`timescale 1ns/1ns
module ptc_cap_src
(
  input  wire logic clk,
  output logic      pin
);
  // The pin idles low between pulses.
  initial pin = 1'b0;
  // Each level is held w clocks; the bench passes three so the timer cannot miss it.
  task automatic pulse(input int w);
    @(posedge clk) pin <= 1'b1;
    repeat (w) @(posedge clk);
    pin <= 1'b0;
    repeat (w) @(posedge clk);
  endtask
endmodule

// >>> sim/periodic_timer_capture_mode_test.sv
// Bench for the timer: register bus tasks and capture scenarios.
// Assumes ptc_timer instance 0 and the pulse source model.
`timescale 1ns/1ns
module periodic_timer_capture_mode_test
  import ptc_pkg::*;
;
  logic        clkSys    = 1'b0;   // Bench clock.
  logic        rstn      = 1'b0;   // Reset to the timer, active low.
  logic        awv       = 1'b0;   // Write address valid.
  logic        wv        = 1'b0;   // Write data valid.
  logic        bRdy      = 1'b0;   // Write response ready.
  logic        arv       = 1'b0;   // Read address valid.
  logic        rRdy      = 1'b0;   // Read data ready.
  logic        tck       = 1'b0;   // Timer clock pin.
  logic        ic        = 1'b0;   // Comparator capture signal.
  logic [3:0]  wS        = 4'hf;   // Write byte strobes.
  logic [7:0]  awA       = 8'h00;  // Write address.
  logic [7:0]  arA       = 8'h00;  // Read address.
  logic [31:0] wD        = 32'h0;  // Write data.
  logic [31:0] d;                  // Read result.
  logic [31:0] c;                  // Saved count.
  logic [1:0]  r;                  // Response code.
  logic        awR;                // Write address ready.
  logic        wR;                 // Write data ready.
  logic        bV;                 // Write response valid.
  logic        arR;                // Read address ready.
  logic        rV;                 // Read data valid.
  logic        cap;                // Capture pin from the source model.
  logic        tOut;               // Timer output.
  logic        irq;                // Timer interrupt.
  logic [1:0]  bR;                 // Write response code.
  logic [1:0]  rR;                 // Read response code.
  logic [31:0] rD;                 // Read data.
  int          error_cnt = 0;      // Mismatches.
  int          n_checks  = 0;      // Comparisons made.
  int          cyc       = 0;      // Cycles run.
  int          irqCnt    = 0;      // Interrupt pulses seen.
  int          outHi     = 0;      // Cycles with the timer output high.
  // Clock at 50 MHz.
  always #10 clkSys = ~clkSys;
  ptc_cap_src src_u (.clk(clkSys), .pin(cap));
  ptc_timer #(.INST(0)) dut_u (.clk_sys(clkSys), .rstn(rstn), .ce(1'b1), .capPin(cap),
    .tckPin(tck), .internalCap(ic), .timerOut(tOut), .timerIrq(irq),
    .s_axi_awaddr(awA), .s_axi_awvalid(awv), .s_axi_awready(awR), .s_axi_wdata(wD),
    .s_axi_wstrb(wS), .s_axi_wvalid(wv), .s_axi_wready(wR), .s_axi_bresp(bR),
    .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arv),
    .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rR), .s_axi_rvalid(rV),
    .s_axi_rready(rRdy));
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cuts a hang short and counts interrupt pulses and output-high cycles.
  always @(posedge clkSys)
  begin
    cyc <= cyc + 1;
    if (irq)
      irqCnt <= irqCnt + 1;
    if (tOut)
      outHi <= outHi + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Write: address and data offered together, each released when taken.
  // Ready stays high between calls, so no signal is driven twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
    awA  <= a;
    wD   <= v;
    awv  <= 1'b1;
    wv   <= 1'b1;
    bRdy <= 1'b1;
    do
    begin
      @(posedge clkSys);
      if (awv && awR)
        awv <= 1'b0;
      if (wv && wR)
        wv <= 1'b0;
    end while (!bV);
    s = bR;
  endtask
  // Read: address held until taken, rready held until data comes.
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    arA  <= a;
    arv  <= 1'b1;
    rRdy <= 1'b1;
    do
    begin
      @(posedge clkSys);
      if (arv && arR)
        arv <= 1'b0;
    end while (!rV);
    v = rD;
    s = rR;
  endtask
  initial
  begin
    repeat (6) @(posedge clkSys);
    rstn <= 1;
    repeat (3) @(posedge clkSys);
    rd(OFF_CTRL, d, r);
    chk(d, 32'h0);
    rd(8'h1c, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLV});
    $display("test reset done");
    // Run in capture mode, stop, then capture the frozen count into A.
    wr(OFF_CTRL, 32'h3, r);
    repeat (20) @(posedge clkSys);
    wr(OFF_CTRL, 32'h2, r);
    rd(OFF_COUNT, c, r);
    chk({31'h0, c != 0}, 32'h1);
    src_u.pulse(3);
    rd(OFF_COMPARE_CAPTURE_A, d, r);
    chk(d, c);
    rd(OFF_STAT, d, r);
    chk(d & 32'h1, 32'h1);
    chk(irqCnt, 32'h1);
    // No-capture edge code leaves A untouched.
    wr(OFF_COMPARE_CAPTURE_A, 32'h55, r);
    wr(OFF_CTRL, 32'h32, r);
    src_u.pulse(3);
    rd(OFF_COMPARE_CAPTURE_A, d, r);
    chk(d, 32'h55);
    // Falling clear with rising edge sends the capture to B.
    wr(OFF_CTRL, 32'h82, r);
    src_u.pulse(3);
    rd(OFF_CAPTURE_REG_B, d, r);
    chk(d, c);
    wr(OFF_CAPTURE_REG_B, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLV});
    $display("test capture done");
    // Short period bounds the count; only the low byte lane is written.
    wS <= 4'h1;
    wr(OFF_PERIOD, 32'h303, r);
    wS <= 4'hf;
    wr(OFF_STAT, 32'h7, r);
    wr(OFF_CTRL, 32'h3, r);
    repeat (30) @(posedge clkSys);
    rd(OFF_COUNT, d, r);
    chk({31'h0, d <= 3}, 32'h1);
    rd(OFF_STAT, d, r);
    chk(d & 32'h2, 32'h2);
    chk({31'h0, irqCnt > 4}, 32'h1);
    $display("test period done");
    // Zero period, both edges, rising clear: the count from rise lands in B at fall.
    wr(OFF_PERIOD, 32'h0, r);
    wr(OFF_CTRL, 32'h63, r);
    src_u.pulse(3);
    rd(OFF_CAPTURE_REG_B, d, r);
    chk(d, 32'h2);
    repeat (8) @(posedge clkSys);
    rd(OFF_COUNT, d, r);
    chk({31'h0, d > 3}, 32'h1);
    $display("test clear done");
    // Comparator source: a stopped count lands in A on its rising edge.
    wr(OFF_CTRL, 32'h2, r);
    wr(OFF_INSRC, 32'h40, r);
    rd(OFF_COUNT, c, r);
    ic <= 1'b1;
    repeat (3) @(posedge clkSys);
    ic <= 1'b0;
    rd(OFF_COMPARE_CAPTURE_A, d, r);
    chk(d, c);
    $display("test source done");
    // Single pulse: the clock pin starts it and compare A ends it.
    chk(outHi, 32'h0);
    wr(OFF_CTRL, 32'h34, r);
    wr(OFF_COMPARE_CAPTURE_A, 32'h5, r);
    tck <= 1'b1;
    repeat (12) @(posedge clkSys);
    tck <= 1'b0;
    chk(outHi, 32'h6);
    rd(OFF_CTRL, d, r);
    chk(d & 32'h1, 32'h0);
    rd(OFF_STAT, d, r);
    chk(d & 32'h4, 32'h4);
    $display("test pulse done");
    print_verdict();
  end
endmodule
